// >>> verilog/psmc_pkg.sv
// Constants, register map and types of the power-save mode controller
package psmc_pkg;
   // ==========================================================
   // Sizes
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int NPERIPH = 8;
   localparam int NIRQ = 8;
   // ==========================================================
   // Register offsets
   localparam logic [ADDR_W-1:0] OFS_RESET_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_PWR_CFG = 8'h02;
   localparam logic [ADDR_W-1:0] OFS_IDLE_STOP = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_TIMER1_CTRL = 8'h06;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
   // ==========================================================
   // Field positions
   localparam int CORE_KEEP_BIT = 8;
   localparam int FLASH_KEEP_BIT = 11;
   localparam int T1_STOP_IDLE_BIT = 13;
   localparam int CFG_WDT_EN_BIT = 0;
   localparam int CFG_FAIL_SAFE_CLOCK_MONITOR_EN_BIT = 1;
   localparam int CFG_CLK_LSB = 2;
   localparam int ST_STATE_LSB = 0;
   localparam int ST_IDLE_BIT = 2;
   localparam int ST_STICKY_LSB = 4;
   // ==========================================================
   // Reset values
   localparam logic [DATA_W-1:0] PWR_CFG_RST = 16'h0000;
   localparam logic [NPERIPH-1:0] IDLE_STOP_RST = 8'h00;
   localparam logic [1:0] CLK_SRC_RST = 2'h0;
   // Source code 3 is the external clock; all others are on-chip
   localparam logic [1:0] CLK_SRC_EXT = 2'h3;
   // ==========================================================
   // Timing: the CPU restarts this many cycles after its clock
   localparam logic [2:0] RESUME_CYC = 3'h3;
   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      PSMC_RUN = 2'h0,
      PSMC_ENTER = 2'h1,
      PSMC_LOW = 2'h3,
      PSMC_WAKE = 2'h2
   } psmc_state_t;
   typedef struct packed {
      logic valid;
      logic idle;
   } psmc_req_t;
   typedef struct packed {
      logic sys_clk_en;
      logic osc_en;
      logic cpu_clk_en;
      logic fail_safe_clock_monitor_active;
      logic low_power_rc_clock_en;
      logic async_keep;
   } psmc_clk_t;
   typedef struct packed {
      logic core_standby;
      logic flash_standby;
   } psmc_vreg_t;
endpackage

// >>> verilog/psmc_sync2.sv
// Two-flop level synchroniser
`timescale 1ns/1ps
module psmc_sync2 (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic d,
   output logic q
);
   logic meta;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         meta <= 1'b0;
         q <= 1'b0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

// >>> verilog/psmc_resume_timer.sv
// Counts the delay between CPU clock restart and resume of execution
`timescale 1ns/1ps
module psmc_resume_timer
   import psmc_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic start,
   output logic done
);
   logic [2:0] cnt;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt <= 3'h0;
      end else if (start) begin
         cnt <= RESUME_CYC;
      end else if (cnt != 3'h0) begin
         cnt <= cnt - 3'h1;
      end
   end

   assign done = (cnt == 3'h1);
endmodule

// >>> verilog/psmc_ctrl.sv
// Power-save controller: Sleep and Idle entry, gating and wake-up
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module psmc_ctrl
   import psmc_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [DATA_W-1:0] rd_data,
   input wire psmc_req_t psav_req,
   input wire logic [NIRQ-1:0] irq_pending,
   input wire logic wdt_timeout_async,
   output psmc_clk_t clk_ctl,
   output psmc_vreg_t vreg_ctl,
   output logic [NPERIPH-1:0] periph_clk_en,
   output logic [1:0] clk_src_sel,
   output logic wdt_clear,
   output logic cpu_resume,
   output logic resume_to_isr
);
   // ==========================================================
   // Declarations
   psmc_state_t state;
   psmc_state_t next_state;
   logic mode_idle;
   logic irq_held;
   logic [1:0] entry_src;
   logic core_keep;
   logic flash_keep;
   logic wdt_en;
   logic fail_safe_clock_monitor_en;
   logic [1:0] clk_src_cfg;
   logic [NPERIPH-1:0] idle_stop;
   logic t1_stop_idle;
   logic [3:0] sticky;
   logic wdt_to;
   logic wake_irq;
   logic wake_any;
   logic resume_done;
   logic next_idle;
   logic next_sleep;
   logic next_low_idle;
   logic [NPERIPH-1:0] stop_mask;
   logic [3:0] sticky_set;
   logic [3:0] sticky_clr;

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction

   // ==========================================================
   // Wake sources
   // The watchdog runs from the RC clock, hence the synchroniser
   psmc_sync2 u_wdt_sync (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .d(wdt_timeout_async),
      .q(wdt_to)
   );

   assign wake_irq = |irq_pending;
   assign wake_any = wake_irq | irq_held | wdt_to;

   psmc_resume_timer u_resume (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .start(state == PSMC_LOW && next_state == PSMC_WAKE),
      .done(resume_done)
   );

   // ==========================================================
   // Mode sequencer
   always_comb begin
      next_state = state;
      case (state)
         PSMC_RUN: begin
            if (psav_req.valid) begin
               next_state = PSMC_ENTER;
            end
         end
         PSMC_ENTER: begin
            next_state = PSMC_LOW;
         end
         PSMC_LOW: begin
            if (wake_any) begin
               next_state = PSMC_WAKE;
            end
         end
         PSMC_WAKE: begin
            if (resume_done) begin
               next_state = PSMC_RUN;
            end
         end
         default: begin
            next_state = PSMC_RUN;
         end
      endcase
   end

   // Any device reset forces the sequencer back to run
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= PSMC_RUN;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_idle <= 1'b0;
         entry_src <= CLK_SRC_RST;
      end else if (state == PSMC_RUN && psav_req.valid) begin
         mode_idle <= psav_req.idle;
         entry_src <= clk_src_cfg;
      end
   end

   // An interrupt seen while entry is in progress is held for later
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_held <= 1'b0;
      end else if (state == PSMC_ENTER && wake_irq) begin
         irq_held <= 1'b1;
      end else if (state != PSMC_ENTER && state != PSMC_LOW) begin
         irq_held <= 1'b0;
      end
   end

   // ==========================================================
   // Clock, power and peripheral gating
   assign next_idle = (next_state == PSMC_RUN) ? psav_req.idle
                                                 : mode_idle;
   assign next_sleep = (next_state == PSMC_LOW) && !next_idle;
   assign next_low_idle = (next_state == PSMC_LOW) && next_idle;
   assign stop_mask = {idle_stop[NPERIPH-1:1], t1_stop_idle};

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         clk_ctl <= '{sys_clk_en: 1'b1, osc_en: 1'b1, cpu_clk_en: 1'b1,
                      fail_safe_clock_monitor_active: 1'b0, low_power_rc_clock_en: 1'b0,
                      async_keep: 1'b1};
      end else begin
         clk_ctl.sys_clk_en <= !next_sleep;
         clk_ctl.osc_en <= !(next_sleep &&
                             entry_src != CLK_SRC_EXT);
         clk_ctl.cpu_clk_en <= (next_state == PSMC_RUN) ||
                               (next_state == PSMC_WAKE);
         clk_ctl.fail_safe_clock_monitor_active <= fail_safe_clock_monitor_en && !next_sleep;
         clk_ctl.low_power_rc_clock_en <= next_sleep ? wdt_en
                                       : (wdt_en | fail_safe_clock_monitor_en);
         clk_ctl.async_keep <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         periph_clk_en <= '1;
      end else if (next_sleep) begin
         periph_clk_en <= '0;
      end else if (next_low_idle) begin
         periph_clk_en <= ~stop_mask;
      end else begin
         periph_clk_en <= '1;
      end
   end

   // Keeping a regulator up trades sleep current for wake-up time
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         vreg_ctl <= '{core_standby: 1'b0, flash_standby: 1'b0};
      end else begin
         vreg_ctl.core_standby <= next_sleep && !core_keep;
         vreg_ctl.flash_standby <= next_sleep &&
                                   !flash_keep;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         clk_src_sel <= CLK_SRC_RST;
      // Live setting in run; entry loads the same value, so no glitch
      end else if (state == PSMC_RUN) begin
         clk_src_sel <= clk_src_cfg;
      end else begin
         clk_src_sel <= entry_src;
      end
   end

   // ==========================================================
   // Watchdog clear and CPU resume strobes
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wdt_clear <= 1'b0;
      end else begin
         wdt_clear <= (state == PSMC_RUN) && psav_req.valid &&
                      wdt_en;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cpu_resume <= 1'b0;
      end else begin
         cpu_resume <= (state == PSMC_WAKE) && resume_done;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         resume_to_isr <= 1'b0;
      end else if (state == PSMC_LOW && wake_any) begin
         resume_to_isr <= wake_irq | irq_held;
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         core_keep <= 1'b0;
         flash_keep <= 1'b0;
      end else if (wr_en && hit(addr, OFS_RESET_CTRL)) begin
         core_keep <= wr_data[CORE_KEEP_BIT];
         flash_keep <= wr_data[FLASH_KEEP_BIT];
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wdt_en <= PWR_CFG_RST[CFG_WDT_EN_BIT];
         fail_safe_clock_monitor_en <= PWR_CFG_RST[CFG_FAIL_SAFE_CLOCK_MONITOR_EN_BIT];
         clk_src_cfg <= CLK_SRC_RST;
      end else if (wr_en && hit(addr, OFS_PWR_CFG)) begin
         wdt_en <= wr_data[CFG_WDT_EN_BIT];
         fail_safe_clock_monitor_en <= wr_data[CFG_FAIL_SAFE_CLOCK_MONITOR_EN_BIT];
         clk_src_cfg <= wr_data[CFG_CLK_LSB +: 2];
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         idle_stop <= IDLE_STOP_RST;
      end else if (wr_en && hit(addr, OFS_IDLE_STOP)) begin
         idle_stop <= wr_data[NPERIPH-1:0];
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         t1_stop_idle <= 1'b0;
      end else if (wr_en && hit(addr, OFS_TIMER1_CTRL)) begin
         t1_stop_idle <= wr_data[T1_STOP_IDLE_BIT];
      end
   end

   // Wake history: {irq, watchdog, from idle, from sleep}, write 1
   // to clear; a new wake event beats a clear in the same cycle
   assign sticky_set = (state == PSMC_LOW && wake_any) ?
      {wake_irq | irq_held, wdt_to, mode_idle, !mode_idle} : 4'h0;
   assign sticky_clr = (wr_en && hit(addr, OFS_STATUS)) ?
      wr_data[ST_STICKY_LSB +: 4] : 4'h0;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sticky <= 4'h0;
      end else begin
         sticky <= (sticky & ~sticky_clr) | sticky_set;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_data <= 16'h0000;
      end else if (!rd_en) begin
         rd_data <= 16'h0000;
      end else if (hit(addr, OFS_RESET_CTRL)) begin
         rd_data <= 16'((32'(flash_keep) << FLASH_KEEP_BIT) |
                        (32'(core_keep) << CORE_KEEP_BIT));
      end else if (hit(addr, OFS_PWR_CFG)) begin
         rd_data <= 16'((32'(clk_src_cfg) << CFG_CLK_LSB) |
                        (32'(fail_safe_clock_monitor_en) << CFG_FAIL_SAFE_CLOCK_MONITOR_EN_BIT) |
                        (32'(wdt_en) << CFG_WDT_EN_BIT));
      end else if (hit(addr, OFS_IDLE_STOP)) begin
         rd_data <= {8'h00, idle_stop};
      end else if (hit(addr, OFS_TIMER1_CTRL)) begin
         rd_data <= 16'(32'(t1_stop_idle) << T1_STOP_IDLE_BIT);
      end else if (hit(addr, OFS_STATUS)) begin
         rd_data <= 16'((32'(sticky) << ST_STICKY_LSB) |
                        (32'(mode_idle) << ST_IDLE_BIT) |
                        (32'(state) << ST_STATE_LSB));
      end else begin
         rd_data <= 16'h0000;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   sequence s_in_sleep;
      state == PSMC_LOW && !mode_idle;
   endsequence

   sequence s_wake_start;
      state == PSMC_LOW ##1 state == PSMC_WAKE;
   endsequence

   chk_sleep_clk_off: assert property (
      s_in_sleep |-> !clk_ctl.sys_clk_en && periph_clk_en == '0)
      else $error("clock or peripherals running in sleep");
   chk_osc_sleep_off: assert property (
      s_in_sleep and (entry_src != CLK_SRC_EXT) |-> !clk_ctl.osc_en)
      else $error("on-chip oscillator running in sleep");
   chk_fail_safe_clock_monitor_sleep_off: assert property (
      s_in_sleep |-> !clk_ctl.fail_safe_clock_monitor_active)
      else $error("clock monitor active in sleep");
   chk_low_power_rc_clock_kept_on: assert property (
      state == PSMC_LOW && (wdt_en || (mode_idle && fail_safe_clock_monitor_en))
      |-> clk_ctl.low_power_rc_clock_en)
      else $error("rc clock stopped while needed");
   chk_wdt_clear_entry: assert property (
      state == PSMC_RUN && psav_req.valid && wdt_en
      |=> wdt_clear && state == PSMC_ENTER ##1 !wdt_clear)
      else $error("watchdog not cleared once on entry");
   chk_icn_keep_on: assert property (
      s_in_sleep |-> clk_ctl.async_keep)
      else $error("async peripherals stopped in sleep");
   chk_wake_exit: assert property (
      state == PSMC_LOW && (wake_irq || wdt_to) |=> state == PSMC_WAKE)
      else $error("wake event did not leave low power");
   chk_clk_src_restore: assert property (
      s_wake_start |-> clk_src_sel == entry_src)
      else $error("clock source not restored on wake");
   chk_vreg_standby: assert property (
      s_in_sleep |-> vreg_ctl.core_standby == !core_keep &&
                     vreg_ctl.flash_standby == !flash_keep)
      else $error("regulator standby wrong in sleep");
   chk_idle_gating: assert property (
      state == PSMC_LOW && mode_idle |-> !clk_ctl.cpu_clk_en &&
      clk_ctl.sys_clk_en && periph_clk_en == ~stop_mask)
      else $error("idle gating wrong");
   chk_resume_delay: assert property (
      s_wake_start |-> clk_ctl.cpu_clk_en && !cpu_resume ##3 cpu_resume)
      else $error("resume not three cycles after clock");
   chk_deferred_irq: assert property (
      state == PSMC_ENTER && wake_irq
      |=> state == PSMC_LOW ##1 state == PSMC_WAKE)
      else $error("interrupt during entry lost");
endmodule

// >>> test/psmc_core_model.sv
// Processor core model that issues the power-save instruction
`timescale 1ns/1ps
// ==========================================
// Core model
module psmc_core_model
   import psmc_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic go,
   input wire logic go_idle,
   input wire logic cpu_resume,
   output psmc_req_t psav_req,
   output logic busy
);
   // A stopped core cannot fetch, so no new instruction until it resumes
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         psav_req <= '0;
         busy <= 1'b0;
      end else begin
         psav_req.valid <= go && !busy;
         psav_req.idle <= go_idle;
         if (go && !busy) begin
            busy <= 1'b1;
         end else if (cpu_resume) begin
            busy <= 1'b0;
         end
      end
   end
endmodule

// >>> test/test_power_save_mode_control.sv
// Self-checking testbench of the power-save mode controller
`timescale 1ns/1ps
module test_power_save_mode_control
   import psmc_pkg::*;
;
   logic core_clk;
   logic arst_n;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wr_data;
   logic wr_en;
   logic rd_en;
   logic [DATA_W-1:0] rd_data;
   psmc_req_t psav_req;
   logic [NIRQ-1:0] irq_pending;
   logic wdt_timeout_async;
   psmc_clk_t clk_ctl;
   psmc_vreg_t vreg_ctl;
   logic [NPERIPH-1:0] periph_clk_en;
   logic [1:0] clk_src_sel;
   logic wdt_clear;
   logic cpu_resume;
   logic resume_to_isr;
   logic go;
   logic go_idle;
   logic core_busy;
   int num_errors;
   int checked;
   int cycles;
   int clears;

   // ==========================================
   // Design and core model
   psmc_ctrl u_dut (.core_clk(core_clk), .arst_n(arst_n), .addr(addr),
      .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .psav_req(psav_req), .irq_pending(irq_pending),
      .wdt_timeout_async(wdt_timeout_async), .clk_ctl(clk_ctl),
      .vreg_ctl(vreg_ctl), .periph_clk_en(periph_clk_en),
      .clk_src_sel(clk_src_sel), .wdt_clear(wdt_clear),
      .cpu_resume(cpu_resume), .resume_to_isr(resume_to_isr));
   psmc_core_model u_core (.core_clk(core_clk), .arst_n(arst_n), .go(go),
      .go_idle(go_idle), .cpu_resume(cpu_resume), .psav_req(psav_req),
      .busy(core_busy));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // ==========================================
   // Watchdog clear pulses and hang limit
   always @(posedge core_clk) begin
      cycles++;
      if (wdt_clear === 1'b1) begin
         clears++;
      end
      if (cycles == 5000) begin
         num_errors++;
         test_done();
      end
   end

   // ==========================================
   // Shared tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask

   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge core_clk);
      wr_en <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp,
      input logic [15:0] m = 16'hFFFF);
      @(posedge core_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge core_clk);
      rd_en <= 1'b0;
      #1;
      check(rd_data & m, exp);
   endtask

   task automatic wait_cpu(input logic lvl, output int n);
      n = 0;
      while (clk_ctl.cpu_clk_en !== lvl && n < 50) begin
         @(posedge core_clk);
         #1;
         n++;
      end
   endtask

   // One entry, low-power check and wake; early raises the interrupt
   // together with the instruction so it must be held off
   task automatic power_save(input logic idle, input logic by_wdt,
      input logic early);
      logic [15:0] keep;
      logic [15:0] cfg;
      logic [15:0] stop;
      logic [15:0] t1;
      logic [NIRQ-1:0] irq;
      logic [1:0] vreg_exp;
      logic [7:0] periph_exp;
      logic [15:0] st_exp;
      int n;
      keep = 16'($urandom) & 16'h0900;
      cfg = 16'($urandom) & 16'h000F;
      stop = 16'($urandom) & 16'h00FF;
      t1 = 16'($urandom) & 16'h2000;
      irq = NIRQ'($urandom) | 8'h01;
      vreg_exp = {~keep[CORE_KEEP_BIT], ~keep[FLASH_KEEP_BIT]};
      periph_exp = ~{stop[7:1], t1[T1_STOP_IDLE_BIT]};
      st_exp = {8'h00, !by_wdt, by_wdt, idle, !idle, 1'b0, idle, 2'b00};
      wr(OFS_RESET_CTRL, keep);
      wr(OFS_PWR_CFG, cfg);
      wr(OFS_IDLE_STOP, stop);
      wr(OFS_TIMER1_CTRL, t1);
      rd_chk(OFS_RESET_CTRL, keep);
      rd_chk(OFS_TIMER1_CTRL, t1);
      clears = 0;
      @(posedge core_clk);
      go <= 1'b1;
      go_idle <= idle;
      @(posedge core_clk);
      go <= 1'b0;
      if (early) begin
         irq_pending <= irq;
      end
      wait_cpu(1'b0, n);
      @(posedge core_clk);
      #1;
      check(clk_ctl.cpu_clk_en, 1'b0);
      check(clk_ctl.sys_clk_en, idle);
      check(clk_ctl.low_power_rc_clock_en, cfg[0] | (idle & cfg[1]));
      check(16'(clears), 16'(cfg[0]));
      if (!idle) begin
         check(periph_clk_en, '0);
         check(clk_ctl.fail_safe_clock_monitor_active, 1'b0);
         check(clk_ctl.async_keep, 1'b1);
         check(vreg_ctl, vreg_exp);
         if (cfg[3:2] != CLK_SRC_EXT) begin
            check(clk_ctl.osc_en, 1'b0);
         end
      end else begin
         check(periph_clk_en, periph_exp);
      end
      if (!early) begin
         repeat ($urandom_range(1, 6)) @(posedge core_clk);
         if (by_wdt) begin
            wdt_timeout_async <= 1'b1;
         end else begin
            irq_pending <= irq;
         end
      end
      wait_cpu(1'b1, n);
      n = 0;
      while (cpu_resume !== 1'b1 && n < 10) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      check(16'(n), 16'(RESUME_CYC));
      check(clk_src_sel, cfg[3:2]);
      check(resume_to_isr, !by_wdt);
      check(periph_clk_en, 8'hFF);
      @(posedge core_clk);
      irq_pending <= '0;
      wdt_timeout_async <= 1'b0;
      rd_chk(OFS_STATUS, st_exp, 16'h00F7);
      wr(OFS_STATUS, 16'h00F0);
   endtask

   // ==========================================
   // Main sequence
   initial begin
      int n;
      arst_n = 1'b0;
      addr = '0;
      wr_data = '0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      irq_pending = '0;
      wdt_timeout_async = 1'b0;
      go = 1'b0;
      go_idle = 1'b0;
      num_errors = 0;
      checked = 0;
      cycles = 0;
      clears = 0;
      void'($urandom(35));
      repeat (20) @(posedge core_clk);
      arst_n <= 1'b1;
      #1;
      check(clk_ctl, 6'h39);
      check(periph_clk_en, 8'hFF);
      for (int i = 0; i < 6; i++) begin
         rd_chk(8'(2 * i), '0);
      end
      wr(8'h0A, 16'hFFFF);
      rd_chk(8'h0A, '0);
      // Table of corner cases first, then random modes and wake causes
      for (int i = 0; i < 8; i++) begin
         power_save(i[0], i[1] & ~i[2], i[2]);
      end
      for (int i = 0; i < 12; i++) begin
         n = $urandom;
         power_save(n[0], n[1], n[2] & ~n[1]);
      end
      // A reset taken while asleep wakes the device
      @(posedge core_clk);
      go <= 1'b1;
      go_idle <= 1'b0;
      @(posedge core_clk);
      go <= 1'b0;
      wait_cpu(1'b0, n);
      repeat (3) @(posedge core_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      #1;
      check(clk_ctl, 6'h39);
      check(vreg_ctl, '0);
      rd_chk(OFS_STATUS, '0);
      test_done();
   end
endmodule
